// ---- logic/timer0_defines.svh ----
// Register offsets, field positions and reset values of the timer block
`ifndef TIMER0_DEFINES_SVH
`define TIMER0_DEFINES_SVH
`define T0_OFF_CONTROL 5'h00
`define T0_OFF_COUNT 5'h04
`define T0_OFF_MASK 5'h08
`define T0_OFF_FLAGS 5'h0c
`define T0_OFF_PRESCALE 5'h10
`define T0_OFF_SYSCTL 5'h14
`define T0_CS_LSB 0
`define T0_CS_MSB 2
`define T0_OVF_BIT 0
`define T0_PSR_BIT 0
`define T0_GIE_BIT 0
`define T0_VACK_BIT 1
`define T0_RST_CONTROL 8'h00
`define T0_RST_COUNT 8'h00
`define T0_RST_MASK 8'h00
`define T0_RST_FLAGS 8'h00
`define T0_PRE_MAX 10'h3ff
`define T0_TAP8 10'h007
`define T0_TAP64 10'h03f
`define T0_TAP256 10'h0ff
`define T0_TAP1024 10'h3ff
`endif

// ---- logic/timer0_pkg.sv ----
// Types of the timer block
package timer0_pkg;
  typedef enum logic [2:0] {
    CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
    CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } clock_select_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : timer0_pkg

// ---- logic/timer0_counter.sv ----
// 8-bit timer with shared prescaler, external pin clock and Wishbone slave
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "timer0_defines.svh"
module timer0_counter
  import timer0_pkg::*;
#(
  parameter int PRE_WIDTH = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic external_count_pin_i,
  input wire logic vector_taken_i,
  output logic [3:0] prescale_taps_o,
  output logic overflow_irq_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] timer0_control;
    logic [7:0] timer0_count;
    logic [7:0] timer_irq_mask;
    logic overflow_flag;
    logic global_irq_enable;
    logic [PRE_WIDTH-1:0] prescale;
    logic pin_meta;
    logic pin_sync;
    logic pin_last;
    bus_state_t bus;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic tap_hit(input logic [PRE_WIDTH-1:0] p,
                                   input logic [9:0] mask);
    tap_hit = ((p & mask[PRE_WIDTH-1:0]) == mask[PRE_WIDTH-1:0]);
  endfunction : tap_hit

  function automatic logic reg_hit(input logic [4:0] a,
                                   input logic [4:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // ==========================================================
  // Clock selection
  logic [3:0] taps;
  logic fall_pulse;
  logic rise_pulse;
  logic timer_clock_enable;
  logic bus_req;
  logic wr_count;
  logic wr_flags;
  logic wr_pre;
  logic bus_wr;
  logic wrap_now;
  clock_select_t cs;

  assign taps[0] = tap_hit(s_q.prescale, `T0_TAP8);
  assign taps[1] = tap_hit(s_q.prescale, `T0_TAP64);
  assign taps[2] = tap_hit(s_q.prescale, `T0_TAP256);
  assign taps[3] = tap_hit(s_q.prescale, `T0_TAP1024);
  assign prescale_taps_o = taps;
  // Edge detect on synchronised copy only; pin direction irrelevant
  assign fall_pulse = s_q.pin_last & ~s_q.pin_sync;
  assign rise_pulse = ~s_q.pin_last & s_q.pin_sync;
  assign cs = clock_select_t'(s_q.timer0_control[`T0_CS_MSB:`T0_CS_LSB]);

  always_comb begin
    case (cs)
      CS_STOP: timer_clock_enable = 1'b0;
      CS_DIV1: timer_clock_enable = 1'b1;
      CS_DIV8: timer_clock_enable = taps[0];
      CS_DIV64: timer_clock_enable = taps[1];
      CS_DIV256: timer_clock_enable = taps[2];
      CS_DIV1024: timer_clock_enable = taps[3];
      CS_EXT_FALL: timer_clock_enable = fall_pulse;
      CS_EXT_RISE: timer_clock_enable = rise_pulse;
      default: timer_clock_enable = 1'b0;
    endcase
  end

  // ==========================================================
  // Register bus decode
  // Reads captured at the taking edge, writes land on the ack edge
  assign bus_req = cyc_i & stb_i & (s_q.bus == BUS_IDLE);
  assign bus_wr = cyc_i & stb_i & we_i & sel_i[0] & (s_q.bus == BUS_ACK);
  assign wr_count = bus_wr & reg_hit(adr_i, `T0_OFF_COUNT);
  assign wr_flags = bus_wr & reg_hit(adr_i, `T0_OFF_FLAGS);
  assign wr_pre = bus_wr & reg_hit(adr_i, `T0_OFF_PRESCALE) &
                  dat_i[`T0_PSR_BIT];
  assign wrap_now = timer_clock_enable & ~wr_count &
                    (s_q.timer0_count == 8'hff);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pin_meta = external_count_pin_i;
    s_d.pin_sync = s_q.pin_meta;
    s_d.pin_last = s_q.pin_sync;
    // Prescale reset self-clears: nothing stored
    if (wr_pre) begin
      s_d.prescale = '0;
    end else begin
      s_d.prescale = s_q.prescale + 1'b1;
    end
    if (wr_count) begin
      s_d.timer0_count = dat_i[7:0];
    end else if (timer_clock_enable) begin
      s_d.timer0_count = s_q.timer0_count + 8'h01;
    end
    // Clear by vector or write-one; a coincident overflow wins
    if (vector_taken_i) begin
      s_d.overflow_flag = 1'b0;
    end
    if (wr_flags && dat_i[`T0_OVF_BIT]) begin
      s_d.overflow_flag = 1'b0;
    end
    if (!wr_count && timer_clock_enable && s_q.timer0_count == 8'hff) begin
      s_d.overflow_flag = 1'b1;
    end
    case (s_q.bus)
      BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          s_d.bus = BUS_ACK;
          s_d.rdata = 32'h0000_0000;
          case (adr_i)
            5'(`T0_OFF_CONTROL): s_d.rdata[7:0] = s_q.timer0_control;
            5'(`T0_OFF_COUNT): s_d.rdata[7:0] = s_q.timer0_count;
            5'(`T0_OFF_MASK): s_d.rdata[7:0] = s_q.timer_irq_mask;
            5'(`T0_OFF_FLAGS): s_d.rdata[`T0_OVF_BIT] = s_q.overflow_flag;
            5'(`T0_OFF_SYSCTL): s_d.rdata[`T0_GIE_BIT] = s_q.global_irq_enable;
            default: s_d.rdata = 32'h0000_0000;
          endcase
        end
      end
      BUS_ACK: begin
        s_d.bus = BUS_IDLE;
        // Request still held at the ack edge; commit the write there
        if (bus_wr) begin
          case (adr_i)
            `T0_OFF_CONTROL: s_d.timer0_control = dat_i[7:0];
            `T0_OFF_MASK: s_d.timer_irq_mask = dat_i[7:0];
            `T0_OFF_SYSCTL: s_d.global_irq_enable = dat_i[`T0_GIE_BIT];
            default: s_d.bus = BUS_IDLE;
          endcase
        end
      end
      default: s_d.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.timer0_control <= `T0_RST_CONTROL;
      s_q.timer0_count <= `T0_RST_COUNT;
      s_q.timer_irq_mask <= `T0_RST_MASK;
      s_q.bus <= BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign ack_o = (s_q.bus == BUS_ACK);
  assign dat_o = s_q.rdata;
  assign overflow_irq_o = s_q.global_irq_enable & s_q.overflow_flag &
                          s_q.timer_irq_mask[`T0_OVF_BIT];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wrap;
    wrap_now;
  endsequence

  sequence s_take;
    bus_req;
  endsequence

  sequence s_pin_fall;
    s_q.pin_last && !s_q.pin_sync;
  endsequence

  sequence s_clear_req;
    vector_taken_i || (wr_flags && dat_i[`T0_OVF_BIT]);
  endsequence

  a_count_step: assert property (timer_clock_enable && !wr_count |=>
    s_q.timer0_count == $past(s_q.timer0_count) + 8'h01)
    else $error("Counter did not step");
  a_count_hold: assert property (!timer_clock_enable && !wr_count |=>
    $stable(s_q.timer0_count)) else $error("Counter moved without enable");
  a_stop_mode: assert property (cs == CS_STOP |-> !timer_clock_enable)
    else $error("Enable while stopped");
  a_full_rate: assert property (cs == CS_DIV1 |-> timer_clock_enable)
    else $error("No enable at full rate");
  a_tap_eight: assert property (cs == CS_DIV8 && timer_clock_enable
    |-> s_q.prescale[2:0] == 3'h7) else $error("Bad divide by 8 tap");
  a_ext_rise: assert property (cs == CS_EXT_RISE && $rose(s_q.pin_sync)
    |-> timer_clock_enable) else $error("Missed rising pin edge");
  a_write_wins: assert property (wr_count |=>
    s_q.timer0_count == $past(dat_i[7:0])) else $error("Write lost");
  a_wrap_flag: assert property (s_wrap |=>
    s_q.timer0_count == 8'h00 && s_q.overflow_flag)
    else $error("Overflow not flagged");
  a_flag_sticky: assert property (!vector_taken_i && !wr_flags
    && s_q.overflow_flag |=> s_q.overflow_flag) else $error("Flag lost");
  a_flag_clear: assert property (wr_flags && dat_i[0] && !wrap_now
    |=> !s_q.overflow_flag) else $error("Flag not cleared");
  a_irq_gate: assert property (overflow_irq_o |-> s_q.overflow_flag
    && s_q.timer_irq_mask[0] && s_q.global_irq_enable)
    else $error("Ungated interrupt");
  a_pre_reset: assert property (wr_pre |=> s_q.prescale == '0)
    else $error("Prescaler not reset");

  // ==========================================================
  // Clock select and prescaler checks
  a_tap_64: assert property (
    cs == CS_DIV64 && timer_clock_enable |-> s_q.prescale[5:0] == 6'h3f)
    else $error("Bad divide by 64 tap");
  a_tap_256: assert property (
    cs == CS_DIV256 && timer_clock_enable |-> s_q.prescale[7:0] == 8'hff)
    else $error("Bad divide by 256 tap");
  a_tap_1024: assert property (
    cs == CS_DIV1024 && timer_clock_enable |-> s_q.prescale[9:0] == 10'h3ff)
    else $error("Bad divide by 1024 tap");
  a_pre_step: assert property (!wr_pre |=>
    s_q.prescale == $past(s_q.prescale) + 1'b1)
    else $error("Prescaler did not run free");
  a_ext_fall: assert property (cs == CS_EXT_FALL ##0 s_pin_fall
    |-> timer_clock_enable) else $error("Missed falling pin edge");
  a_ext_quiet: assert property (
    cs inside {CS_EXT_FALL, CS_EXT_RISE} && s_q.pin_last == s_q.pin_sync
    |-> !timer_clock_enable) else $error("Pin enable without edge");
  a_pulse_once: assert property (rise_pulse |=> !rise_pulse)
    else $error("Rise pulse longer than one cycle");
  a_sync_chain: assert property (1'b1 |=>
    s_q.pin_sync == $past(s_q.pin_meta) &&
    s_q.pin_last == $past(s_q.pin_sync))
    else $error("Pin synchroniser broken");

  // ==========================================================
  // Flag and interrupt checks
  a_vector_clear: assert property (vector_taken_i && !wrap_now |=>
    !s_q.overflow_flag) else $error("Vector did not clear flag");
  a_set_wins: assert property (s_clear_req ##0 wrap_now |=>
    s_q.overflow_flag) else $error("Clear beat a coincident overflow");
  a_flag_rise: assert property ($rose(s_q.overflow_flag) |->
    $past(wrap_now)) else $error("Flag set without wrap");
  a_irq_on: assert property (
    s_q.global_irq_enable && s_q.overflow_flag &&
    s_q.timer_irq_mask[`T0_OVF_BIT] |-> overflow_irq_o)
    else $error("Interrupt not raised");

  // ==========================================================
  // Bus checks
  a_ack_answer: assert property (s_take |=> ack_o)
    else $error("No ack one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("Ack held too long");
  a_pre_reads_zero: assert property (
    s_take ##0 (adr_i == `T0_OFF_PRESCALE) |=> dat_o == 32'h0000_0000)
    else $error("Prescaler reset bit read nonzero");
  a_ctl_write: assert property (
    bus_wr && reg_hit(adr_i, `T0_OFF_CONTROL) |=>
    s_q.timer0_control == $past(dat_i[7:0]))
    else $error("Control write lost");
  a_mask_write: assert property (
    bus_wr && reg_hit(adr_i, `T0_OFF_MASK) |=>
    s_q.timer_irq_mask == $past(dat_i[7:0]))
    else $error("Mask write lost");

endmodule : timer0_counter

// ---- testbench/count_pin_model.sv ----
// Count pin driver standing in for software toggling the port pin
`timescale 1ns/1ps
module count_pin_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] edges_i,
  output logic pin_o,
  output logic busy_o
);
  logic [7:0] left_q = 8'h00;
  logic [1:0] gap_q = 2'h0;
  initial pin_o = 1'b0;
  // Three cycles per level so every level is sampled
  always @(posedge clk_i) begin
    if (go_i) begin
      left_q <= edges_i;
    end else if (left_q != 8'h00) begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      if (gap_q == 2'h2) begin
        pin_o <= ~pin_o;
        left_q <= left_q - 8'h01;
      end
    end
  end
  assign busy_o = left_q != 8'h00;
endmodule : count_pin_model

// ---- testbench/timer0_counter_test.sv ----
// Self-checking bench for the 8-bit timer with a cycle-exact model
`timescale 1ns/1ps
module timer0_counter_test;
  import timer0_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic vector_taken_i = 0, go = 0, pin, busy, ack_o, overflow_irq_o;
  logic [4:0] adr_i = 0;
  logic [3:0] sel_i = 0, prescale_taps_o, t;
  logic [31:0] dat_i = 0, dat_o;
  logic [7:0] n_edges = 0, m_cnt, m_exp;
  logic [2:0] m_cs, m_p;
  logic [9:0] m_pre;
  logic m_ovf, m_msk, m_gie, en, wr;
  int bad_count = 0, compares = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  timer0_counter dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_pin_i(pin), .vector_taken_i(vector_taken_i),
    .prescale_taps_o(prescale_taps_o), .overflow_irq_o(overflow_irq_o));
  count_pin_model pm (.clk_i(clk_i), .go_i(go), .edges_i(n_edges),
    .pin_o(pin), .busy_o(busy));
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
  endtask : wb
  // Reference model, updated on the values seen at each edge
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      summarize();
    end
    t = {m_pre == 10'h3ff, m_pre[7:0] == 8'hff, m_pre[5:0] == 6'h3f,
      m_pre[2:0] == 3'h7};
    wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    if (rst_i) begin
      {m_cnt, m_exp, m_cs, m_pre, m_ovf, m_msk, m_gie, m_p} = '0;
    end else begin
      check(prescale_taps_o === t, "taps");
      check(overflow_irq_o === (m_gie & m_msk & m_ovf), "irq");
      if (ack_o === 1'b1 && !we_i)
        check(dat_o === {24'h0, m_exp}, "read");
      if (cyc_i && stb_i && !we_i && !ack_o)
        m_exp = adr_i == 0 ? {5'h0, m_cs} : adr_i == 4 ? m_cnt :
          adr_i == 8 ? {7'h0, m_msk} : adr_i == 12 ? {7'h0, m_ovf} :
          adr_i == 20 ? {7'h0, m_gie} : 8'h00;
      case (m_cs)
        1: en = 1;
        2, 3, 4, 5: en = t[m_cs-2];
        6: en = m_p[2] & !m_p[1];
        7: en = !m_p[2] & m_p[1];
        default: en = 0;
      endcase
      if ((wr && adr_i == 12 && dat_i[0]) || vector_taken_i) m_ovf = 0;
      if (wr && adr_i == 4) m_cnt = dat_i[7:0];
      else if (en) m_cnt = m_cnt + 8'h01;
      if (en && !(wr && adr_i == 4) && m_cnt == 0) m_ovf = 1;
      m_pre = (wr && adr_i == 16 && dat_i[0]) ? 10'h0 : m_pre + 10'h1;
      if (wr && adr_i == 0) m_cs = dat_i[2:0];
      if (wr && adr_i == 8) m_msk = dat_i[0];
      if (wr && adr_i == 20) m_gie = dat_i[0];
      m_p = {m_p[1:0], pin};
    end
  end
  initial begin
    void'($urandom(76));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 28; a += 4)
      wb(0, 5'(a), 0);
    wb(1, 4, 8'($urandom));
    repeat (30) @(posedge clk_i);
    wb(0, 4, 0);
    wb(1, 20, 1);
    wb(1, 8, 1);
    wb(1, 4, 8'hf0);
    wb(1, 0, 1);
    repeat ($urandom_range(20, 300)) @(posedge clk_i);
    wb(1, 4, 8'hfe);
    wb(0, 4, 0);
    wb(0, 12, 0);
    wb(1, 12, 0);
    wb(1, 12, 1);
    repeat (300) @(posedge clk_i);
    vector_taken_i <= 1;
    @(posedge clk_i);
    vector_taken_i <= 0;
    wb(1, 8, 0);
    repeat (300) @(posedge clk_i);
    wb(0, 12, 0);
    for (int c = 2; c < 6; c++) begin
      wb(1, 16, 1);
      wb(1, 0, 8'(c));
      repeat (2100) @(posedge clk_i);
      wb(0, 4, 0);
    end
    for (int c = 6; c < 8; c++) begin
      wb(1, 4, 0);
      wb(1, 0, 8'(c));
      go <= 1;
      n_edges <= 8'($urandom_range(1, 60));
      @(posedge clk_i);
      go <= 0;
      do @(posedge clk_i); while (busy);
      repeat (8) @(posedge clk_i);
      wb(0, 4, 0);
    end
    summarize();
  end
endmodule : timer0_counter_test
